// >>> hdl/rtccp_regs.svh
/*
  Register indices, field positions, reset values and timing counts of the
  RTC compare and periodic interrupt timer block.
  Assumes an AXI4-Lite bus with 32-bit data; byte address = 4 * index.
*/
`ifndef RTCCP_REGS_SVH
`define RTCCP_REGS_SVH

`define RTCCP_IDX_CLK_SEL    8'h07
`define RTCCP_IDX_CMP_LOW    8'h0C
`define RTCCP_IDX_CMP_HIGH   8'h0D
`define RTCCP_IDX_PER_CTRL   8'h10
`define RTCCP_IDX_PER_STAT   8'h11
`define RTCCP_IDX_PER_IRQEN  8'h12
`define RTCCP_IDX_PER_FLAG   8'h13
`define RTCCP_IDX_PER_DBG    8'h15
`define RTCCP_IDX_IRQ_STAT   8'h20
`define RTCCP_IDX_IRQ_CLR    8'h21
`define RTCCP_IDX_IRQ_EN     8'h22

`define RTCCP_RST_BYTE       8'h00
`define RTCCP_RST_WORD       16'h0000
`define RTCCP_PER_LSB        3
`define RTCCP_PER_MSB        6
`define RTCCP_PER_OFF        4'h0
`define RTCCP_PER_RSVD       4'hF
`define RTCCP_BIT_PER_IRQ    0
`define RTCCP_BIT_CMP_IRQ    1
`define RTCCP_CLK_32K        2'h0
`define RTCCP_CLK_1K         2'h1
`define RTCCP_CLK_EXT        2'h3
`define RTCCP_DIV_1K_LAST    5'h1F
`define RTCCP_RESP_OKAY      2'h0
`define RTCCP_RESP_SLVERR    2'h2

`endif

// >>> hdl/rtccp_pkg.sv
/*
  Types of the RTC compare and periodic interrupt timer block.
  Assumes rtccp_regs.svh for all numeric constants.
*/
package rtccp_pkg;

  typedef enum logic [1:0] {
    SYNC_IDLE,
    SYNC_FIRST,
    SYNC_SECOND
  } rtccp_sync_e;

  typedef struct packed {
    logic [15:0] cmp;
    logic [7:0]  per_ctrl_wr;
    logic [7:0]  per_ctrl_rtc;
    rtccp_sync_e sync;
    logic        per_irq_en;
    logic        cmp_irq_en;
    logic [1:0]  flags;
    logic        run_in_debug;
    logic [1:0]  clk_sel;
    logic [15:0] rtc_cnt;
    logic [14:0] pit_cnt;
    logic [4:0]  div_1k;
    logic        aw_hold;
    logic [7:0]  aw_idx;
    logic        w_hold;
    logic [7:0]  w_byte;
    logic        w_lane0;
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [7:0]  rdata;
    logic [1:0]  rresp;
    logic        irq;
  } rtccp_state_s;

endpackage

// >>> hdl/rtccp_top.sv
/*
  RTC compare register and periodic interrupt timer, with AXI4-Lite registers.
  Assumes the RTC clock arrives as one-cycle tick enables synchronous to
  I_CORE_CLK, and a level I_DEBUG_HALT that is high while the CPU is halted.
*/
// Implementation choice: register access over AXI4-Lite.
`include "rtccp_regs.svh"

// What this block does, and what software must do
// RULE1: Compare value is held as low byte at base, high byte at base plus one.
// RULE2: Count equal to compare sets compare flag; written one clears it.
// RULE3: Period field bits 6:3 selects 4 to 32768 ticks; zero and 0xF none.
// RULE4: Control bit zero one enables the periodic timer, zero disables it.
// RULE5: Read-only busy bit is high while control moves into the RTC domain.
// RULE6: Interrupt control bit zero gates the periodic interrupt request.
// RULE7: Periodic flag sets each time the selected interval ends.
// RULE8: Written one clears the periodic flag; written zero leaves it.
// RULE9: With debug-run set the periodic timer keeps running in debug halt.
// RULE10: With debug-run clear the periodic timer halts and ignores ticks.
// RULE11: All registers of this block reset to zero.
// RULE12: Two-bit clock select picks 32.768 kHz, 1.024 kHz, none, or external.
// RULE13: Software waits for busy low before rewriting the periodic control.
module rtccp_top
  import rtccp_pkg::*;
#(
  parameter int AW = 12
) (
  input  wire logic          I_CORE_CLK,
  input  wire logic          I_SRST,
  input  wire logic          I_TICK_32K,
  input  wire logic          I_TICK_EXT,
  input  wire logic          I_DEBUG_HALT,
  input  wire logic [AW-1:0] I_AWADDR,
  input  wire logic          I_AWVALID,
  output logic               O_AWREADY,
  input  wire logic [31:0]   I_WDATA,
  input  wire logic [3:0]    I_WSTRB,
  input  wire logic          I_WVALID,
  output logic               O_WREADY,
  output logic [1:0]         O_BRESP,
  output logic               O_BVALID,
  input  wire logic          I_BREADY,
  input  wire logic [AW-1:0] I_ARADDR,
  input  wire logic          I_ARVALID,
  output logic               O_ARREADY,
  output logic [31:0]        O_RDATA,
  output logic [1:0]         O_RRESP,
  output logic               O_RVALID,
  input  wire logic          I_RREADY,
  output logic               O_IRQ
);

  rtccp_state_s s_q;
  rtccp_state_s s_d;
  logic         tick;
  logic         pit_run;
  logic         pit_fire;
  logic         wr_fire;
  logic         cmp_hit;
  logic [3:0]   per_code;
  logic [14:0]  per_mask;
  logic [1:0]   set_flags;
  logic [1:0]   clr_flags;
  logic [7:0]   ar_idx;

  function automatic logic idx_mapped(input logic [7:0] idx);
    idx_mapped = (idx == `RTCCP_IDX_CLK_SEL) || (idx == `RTCCP_IDX_CMP_LOW) ||
                 (idx == `RTCCP_IDX_CMP_HIGH) || (idx == `RTCCP_IDX_PER_CTRL) ||
                 (idx == `RTCCP_IDX_PER_STAT) || (idx == `RTCCP_IDX_PER_IRQEN) ||
                 (idx == `RTCCP_IDX_PER_FLAG) || (idx == `RTCCP_IDX_PER_DBG) ||
                 (idx == `RTCCP_IDX_IRQ_STAT) || (idx == `RTCCP_IDX_IRQ_CLR) ||
                 (idx == `RTCCP_IDX_IRQ_EN);
  endfunction

  always_comb begin
    s_d       = s_q;
    set_flags = 2'h0;
    clr_flags = 2'h0;
    cmp_hit   = 1'b0;
    ar_idx    = I_ARADDR[9:2];
    unique case (s_q.clk_sel) // RULE12
      `RTCCP_CLK_32K: tick = I_TICK_32K;
      `RTCCP_CLK_1K:  tick = I_TICK_32K && (s_q.div_1k == `RTCCP_DIV_1K_LAST);
      `RTCCP_CLK_EXT: tick = I_TICK_EXT;
      default:        tick = 1'b0;
    endcase
    if (I_TICK_32K) begin
      s_d.div_1k = s_q.div_1k + 5'h01;
    end
    // Compare runs on every tick; the match is taken on the new count value.
    if (tick) begin
      s_d.rtc_cnt = s_q.rtc_cnt + 16'h0001;
      cmp_hit     = (s_d.rtc_cnt == s_q.cmp); // RULE2
    end
    per_code = s_q.per_ctrl_rtc[`RTCCP_PER_MSB:`RTCCP_PER_LSB];
    per_mask = 15'((17'h00002 << per_code) - 17'h00001);
    pit_run  = s_q.per_ctrl_rtc[0] && (per_code != `RTCCP_PER_OFF) && // RULE4
               (per_code != `RTCCP_PER_RSVD) && // RULE3
               !(I_DEBUG_HALT && !s_q.run_in_debug); // RULE9 RULE10
    pit_fire = pit_run && tick && ((s_q.pit_cnt & per_mask) == per_mask); // RULE3
    if (!s_q.per_ctrl_rtc[0]) begin
      s_d.pit_cnt = 15'h0000; // RULE4
    end else if (pit_run && tick) begin
      s_d.pit_cnt = s_q.pit_cnt + 15'h0001;
    end
    // The written control value needs two RTC ticks before it takes effect.
    if (tick) begin
      unique case (s_q.sync) // RULE5
        SYNC_FIRST:  s_d.sync = SYNC_SECOND;
        SYNC_SECOND: begin
          s_d.sync         = SYNC_IDLE;
          s_d.per_ctrl_rtc = s_q.per_ctrl_wr;
        end
        SYNC_IDLE:   s_d.sync = SYNC_IDLE;
      endcase
    end
    set_flags[`RTCCP_BIT_PER_IRQ] = pit_fire; // RULE7
    set_flags[`RTCCP_BIT_CMP_IRQ] = cmp_hit; // RULE2
    if (I_AWVALID && s_q.awready) begin
      s_d.aw_hold = 1'b1;
      s_d.aw_idx  = I_AWADDR[9:2];
    end
    if (I_WVALID && s_q.wready) begin
      s_d.w_hold  = 1'b1;
      s_d.w_byte  = I_WDATA[7:0];
      s_d.w_lane0 = I_WSTRB[0];
    end
    wr_fire = s_q.aw_hold && s_q.w_hold && !s_q.bvalid;
    if (wr_fire) begin
      s_d.aw_hold = 1'b0;
      s_d.w_hold  = 1'b0;
      s_d.bvalid  = 1'b1;
      s_d.bresp   = idx_mapped(s_q.aw_idx) ? `RTCCP_RESP_OKAY : `RTCCP_RESP_SLVERR;
      if (s_q.w_lane0) begin
        unique case (s_q.aw_idx)
          `RTCCP_IDX_CLK_SEL:   s_d.clk_sel = s_q.w_byte[1:0]; // RULE12
          `RTCCP_IDX_CMP_LOW:   s_d.cmp[7:0] = s_q.w_byte; // RULE1
          `RTCCP_IDX_CMP_HIGH:  s_d.cmp[15:8] = s_q.w_byte; // RULE1
          `RTCCP_IDX_PER_CTRL: begin
            // A rewrite while busy restarts the transfer; the older value is lost unless its second tick falls in the same cycle.
            s_d.per_ctrl_wr = {1'b0, s_q.w_byte[6:3], 2'b00, s_q.w_byte[0]};
            s_d.sync        = SYNC_FIRST; // RULE5 RULE13
          end
          `RTCCP_IDX_PER_IRQEN: s_d.per_irq_en = s_q.w_byte[0]; // RULE6
          `RTCCP_IDX_PER_FLAG:  clr_flags[`RTCCP_BIT_PER_IRQ] = s_q.w_byte[0]; // RULE8
          `RTCCP_IDX_PER_DBG:   s_d.run_in_debug = s_q.w_byte[0]; // RULE9
          `RTCCP_IDX_IRQ_CLR:   clr_flags = s_q.w_byte[1:0]; // RULE2 RULE8
          `RTCCP_IDX_IRQ_EN: begin
            s_d.per_irq_en = s_q.w_byte[`RTCCP_BIT_PER_IRQ];
            s_d.cmp_irq_en = s_q.w_byte[`RTCCP_BIT_CMP_IRQ];
          end
          default: ;
        endcase
      end
    end
    // A hardware set in the clearing cycle wins, so no event is lost.
    s_d.flags = (s_q.flags & ~clr_flags) | set_flags; // RULE2 RULE7 RULE8
    if (s_q.bvalid && I_BREADY) begin
      s_d.bvalid = 1'b0;
    end
    s_d.awready = !s_d.aw_hold && !s_d.bvalid;
    s_d.wready  = !s_d.w_hold && !s_d.bvalid;
    if (s_q.rvalid && I_RREADY) begin
      s_d.rvalid = 1'b0;
    end
    if (I_ARVALID && s_q.arready) begin
      s_d.rvalid = 1'b1;
      s_d.rresp  = idx_mapped(ar_idx) ? `RTCCP_RESP_OKAY : `RTCCP_RESP_SLVERR;
      unique case (ar_idx)
        `RTCCP_IDX_CLK_SEL:   s_d.rdata = {6'h00, s_q.clk_sel};
        `RTCCP_IDX_CMP_LOW:   s_d.rdata = s_q.cmp[7:0];
        `RTCCP_IDX_CMP_HIGH:  s_d.rdata = s_q.cmp[15:8];
        `RTCCP_IDX_PER_CTRL:  s_d.rdata = s_q.per_ctrl_wr;
        `RTCCP_IDX_PER_STAT:  s_d.rdata = {7'h00, s_q.sync != SYNC_IDLE}; // RULE5
        `RTCCP_IDX_PER_IRQEN: s_d.rdata = {7'h00, s_q.per_irq_en};
        `RTCCP_IDX_PER_FLAG:  s_d.rdata = {7'h00, s_q.flags[`RTCCP_BIT_PER_IRQ]};
        `RTCCP_IDX_PER_DBG:   s_d.rdata = {7'h00, s_q.run_in_debug};
        `RTCCP_IDX_IRQ_STAT:  s_d.rdata = {6'h00, s_q.flags};
        `RTCCP_IDX_IRQ_EN:    s_d.rdata = {6'h00, s_q.cmp_irq_en, s_q.per_irq_en};
        default:              s_d.rdata = 8'h00;
      endcase
    end
    s_d.arready = !s_d.rvalid;
    s_d.irq = |(s_d.flags & {s_d.cmp_irq_en, s_d.per_irq_en}); // RULE6
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (I_SRST) begin
      s_q <= '0; // RULE11
    end else begin
      s_q <= s_d;
    end
  end

  assign O_AWREADY = s_q.awready;
  assign O_WREADY  = s_q.wready;
  assign O_BVALID  = s_q.bvalid;
  assign O_BRESP   = s_q.bresp;
  assign O_ARREADY = s_q.arready;
  assign O_RVALID  = s_q.rvalid;
  assign O_RRESP   = s_q.rresp;
  assign O_RDATA   = {24'h000000, s_q.rdata};
  assign O_IRQ     = s_q.irq;

  // Reference count of live timer ticks, kept apart from the timer's own counter so a
  // wrong interval shows up. It is trusted only from a known start: disabled or just fired.
  logic [15:0] ivl_cnt_q;
  logic        ivl_ok_q;

  always_ff @(posedge I_CORE_CLK) begin
    if (I_SRST || !s_q.per_ctrl_rtc[0] || pit_fire) begin
      ivl_cnt_q <= 16'h0000;
      ivl_ok_q  <= 1'b1;
    end else if (pit_run && tick) begin
      ivl_cnt_q <= ivl_cnt_q + 16'h0001;
    end
    // A new control value under a running timer leaves its count unaligned.
    if (!I_SRST && s_q.per_ctrl_rtc[0] && s_q.sync == SYNC_SECOND && tick) begin
      ivl_ok_q <= 1'b0;
    end
  end

  // The assertions watch registered state and the tick decode; bus and tick inputs are
  // left free, so the checks hold for any legal master.
  default clocking cb @(posedge I_CORE_CLK);
  endclocking
  default disable iff (I_SRST);

  AST_CMP_BYTES: // RULE1
  assert property (wr_fire && s_q.w_lane0 && s_q.aw_idx == `RTCCP_IDX_CMP_HIGH
                   |=> s_q.cmp[15:8] == $past(s_q.w_byte) && $stable(s_q.cmp[7:0]))
    else $error("Compare high byte write went wrong.");

  AST_CMP_LOW: // RULE1
  assert property (wr_fire && s_q.w_lane0 && s_q.aw_idx == `RTCCP_IDX_CMP_LOW
                   |=> s_q.cmp[7:0] == $past(s_q.w_byte) && $stable(s_q.cmp[15:8]))
    else $error("Compare low byte write went wrong.");

  AST_CMP_MATCH: // RULE2
  assert property (tick && (s_q.rtc_cnt + 16'h0001) == s_q.cmp |=> s_q.flags[1])
    else $error("Compare match did not set its flag.");

  AST_CMP_CLEAR: // RULE2
  assert property (wr_fire && s_q.w_lane0 && s_q.aw_idx == `RTCCP_IDX_IRQ_CLR &&
                   s_q.w_byte[1] && !cmp_hit |=> !s_q.flags[1])
    else $error("Compare flag not cleared by a written one.");

  AST_PER_INTERVAL: // RULE3
  assert property (pit_fire |-> per_code != `RTCCP_PER_OFF &&
                   per_code != `RTCCP_PER_RSVD &&
                   (!ivl_ok_q || (ivl_cnt_q + 16'h0001) == (16'h0002 << per_code)))
    else $error("Periodic interrupt at a wrong point.");

  AST_PER_DISABLE: // RULE4
  assert property (!s_q.per_ctrl_rtc[0] |=> s_q.pit_cnt == 15'h0000 && !pit_fire)
    else $error("Disabled periodic timer still counts.");

  AST_BUSY_HOLD: // RULE5
  assert property (wr_fire && s_q.w_lane0 && s_q.aw_idx == `RTCCP_IDX_PER_CTRL
                   |=> s_q.sync == SYNC_FIRST ##1 s_q.sync != SYNC_IDLE)
    else $error("Busy not raised by a control write.");

  AST_BUSY_CLEAR: // RULE5
  assert property (s_q.sync == SYNC_SECOND && tick &&
                   !(wr_fire && s_q.w_lane0 && s_q.aw_idx == `RTCCP_IDX_PER_CTRL)
                   |=> s_q.sync == SYNC_IDLE && s_q.per_ctrl_rtc == $past(s_q.per_ctrl_wr))
    else $error("Control value did not land when busy dropped.");

  AST_IRQ_GATE: // RULE6
  assert property (O_IRQ == ((s_q.flags[`RTCCP_BIT_PER_IRQ] && s_q.per_irq_en) ||
                             (s_q.flags[`RTCCP_BIT_CMP_IRQ] && s_q.cmp_irq_en)))
    else $error("Interrupt output does not follow enabled flags.");

  AST_PER_SET: // RULE7
  assert property (pit_fire |=> s_q.flags[0])
    else $error("Periodic flag not set.");

  AST_PER_CLEAR: // RULE8
  assert property (wr_fire && s_q.w_lane0 && s_q.aw_idx == `RTCCP_IDX_PER_FLAG &&
                   !pit_fire |=> s_q.flags[0] == ($past(s_q.flags[0]) && !$past(s_q.w_byte[0])))
    else $error("Periodic flag clear misbehaved.");

  AST_DEBUG_RUN: // RULE9
  assert property (I_DEBUG_HALT && s_q.run_in_debug && s_q.per_ctrl_rtc[0] && tick &&
                   per_code != `RTCCP_PER_OFF && per_code != `RTCCP_PER_RSVD
                   |=> s_q.pit_cnt == $past(s_q.pit_cnt) + 15'h0001)
    else $error("Periodic timer stopped in debug run.");

  AST_DEBUG_HALT: // RULE10
  assert property (I_DEBUG_HALT && !s_q.run_in_debug && s_q.per_ctrl_rtc[0]
                   |-> !pit_fire ##1 $stable(s_q.pit_cnt))
    else $error("Periodic timer moved while halted.");

  AST_RESET_ZERO: // RULE11
  assert property ($past(I_SRST) |-> s_q.cmp == `RTCCP_RST_WORD && s_q.flags == 2'h0 &&
                   s_q.per_ctrl_wr == `RTCCP_RST_BYTE && !O_IRQ)
    else $error("Registers not zero after reset.");

  AST_CLK_RESERVED: // RULE12
  assert property (s_q.clk_sel == 2'h2 |-> !tick)
    else $error("Reserved clock select produced ticks.");

  CVR_PER_FIRE: cover property (pit_fire && s_q.per_irq_en);
  CVR_CMP_HIT:  cover property (cmp_hit ##1 O_IRQ);
  CVR_SYNC:     cover property (s_q.sync == SYNC_SECOND && tick);
  CVR_SET_CLR:  cover property (pit_fire && wr_fire && s_q.aw_idx == `RTCCP_IDX_PER_FLAG);
  CVR_EXT_FIRE: cover property (s_q.clk_sel == `RTCCP_CLK_EXT && pit_fire);

endmodule

// >>> dv/tb_top.sv
/*
  Self-checking testbench of the RTC compare and periodic interrupt timer block.
  Assumes rtccp_top with its AXI4-Lite registers and ticks synchronous to the core clock.
*/
`include "rtccp_regs.svh"

`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin n_errors++; \
  $display("Error %s expected %0h seen %0h", nm, e, g); end end

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic        core_clk = 1'b0;
  logic        srst     = 1'b1;
  logic        tick_32k = 1'b0;
  logic        tick_ext = 1'b0;
  logic        dbg_halt = 1'b0;
  logic [11:0] awaddr   = 12'h000;
  logic        awvalid  = 1'b0;
  logic [31:0] wdata    = 32'h0;
  logic        wvalid   = 1'b0;
  logic        bready   = 1'b0;
  logic [11:0] araddr   = 12'h000;
  logic        arvalid  = 1'b0;
  logic        rready   = 1'b0;
  logic        o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_irq;
  logic [1:0]  o_bresp, o_rresp;
  logic [31:0] o_rdata, rv;
  logic [1:0]  rr;
  logic        tick_on  = 1'b1;
  logic [3:0]  tdiv     = 4'h0;
  logic [15:0] n_ticks  = 16'h0;
  logic [15:0] c;
  int          n_errors = 0;
  int          n_tests  = 0;
  logic [7:0]  ra [10] = '{8'h0C, 8'h0D, 8'h10, 8'h11, 8'h12, 8'h13, 8'h15, 8'h07, 8'h20, 8'h22};
  logic [7:0]  ctl [2] = '{8'h79, 8'h08};

  rtccp_top rtccp_top_inst (
    .I_CORE_CLK(core_clk), .I_SRST(srst), .I_TICK_32K(tick_32k), .I_TICK_EXT(tick_ext),
    .I_DEBUG_HALT(dbg_halt), .I_AWADDR(awaddr), .I_AWVALID(awvalid), .O_AWREADY(o_awready),
    .I_WDATA(wdata), .I_WSTRB(4'h1), .I_WVALID(wvalid), .O_WREADY(o_wready),
    .O_BRESP(o_bresp), .O_BVALID(o_bvalid), .I_BREADY(bready), .I_ARADDR(araddr),
    .I_ARVALID(arvalid), .O_ARREADY(o_arready), .O_RDATA(o_rdata), .O_RRESP(o_rresp),
    .O_RVALID(o_rvalid), .I_RREADY(rready), .O_IRQ(o_irq)
  );

  initial begin
    forever #5 core_clk = ~core_clk;
  end

  // Ticks come every tenth cycle; the bench keeps its own count of the free counter.
  always @(posedge core_clk) begin
    tdiv <= (tdiv == 4'h9) ? 4'h0 : tdiv + 4'h1;
    tick_32k <= tick_on && (tdiv == 4'h9) && !srst;
    if (tick_32k && !srst) n_ticks <= n_ticks + 16'h1;
  end

  function automatic logic [11:0] ba(input logic [7:0] idx);
    return {2'b00, idx, 2'b00};
  endfunction

  task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] er);
    logic aw_d, w_d;
    aw_d = 1'b0;
    w_d = 1'b0;
    @(posedge core_clk);
    awaddr <= ba(idx);
    awvalid <= 1'b1;
    wdata <= {24'h0, d};
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge core_clk);
      if (!aw_d && o_awready) begin
        aw_d = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_d && o_wready) begin
        w_d = 1'b1;
        wvalid <= 1'b0;
      end
      if (o_bvalid) break;
    end
    bready <= 1'b0;
    `CHK("bresp", er, o_bresp)
  endtask

  task automatic peek(input logic [7:0] idx);
    logic ar_d;
    ar_d = 1'b0;
    @(posedge core_clk);
    araddr <= ba(idx);
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge core_clk);
      if (!ar_d && o_arready) begin
        ar_d = 1'b1;
        arvalid <= 1'b0;
      end
      if (o_rvalid) break;
    end
    rv = o_rdata;
    rr = o_rresp;
    rready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] idx, input logic [31:0] e, input logic [1:0] er);
    peek(idx);
    `CHK("rdata", e, rv)
    `CHK("rresp", er, rr)
  endtask

  task automatic wait_irq();
    for (int t = 0; t < 5000 && o_irq !== 1'b1; t++) @(posedge core_clk);
  endtask

  // Busy drops once the control value has crossed; the poll is bounded.
  task automatic wait_sync();
    peek(`RTCCP_IDX_PER_STAT);
    for (int t = 0; t < 100 && rv[0] !== 1'b0; t++) peek(`RTCCP_IDX_PER_STAT);
  endtask

  // Each external tick stands for exactly one clock edge.
  task automatic ext_pulse(input int n);
    repeat (n) begin
      tick_ext <= 1'b1;
      @(posedge core_clk);
      tick_ext <= 1'b0;
      @(posedge core_clk);
    end
  endtask

  task automatic results();
    if (n_errors == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    repeat (100000) @(posedge core_clk);
    n_errors++;
    results();
  end

  initial begin
    repeat (16) @(posedge core_clk);
    srst <= 1'b0;
    foreach (ra[i]) rd(ra[i], 32'h0, `RTCCP_RESP_OKAY);
    rd(8'h3F, 32'h0, `RTCCP_RESP_SLVERR);
    wr(8'h3F, 8'hFF, `RTCCP_RESP_SLVERR);
    c = n_ticks + 16'h0120;
    wr(`RTCCP_IDX_CMP_LOW, c[7:0], `RTCCP_RESP_OKAY);
    wr(`RTCCP_IDX_CMP_HIGH, c[15:8], `RTCCP_RESP_OKAY);
    rd(`RTCCP_IDX_CMP_LOW, {24'h0, c[7:0]}, `RTCCP_RESP_OKAY);
    rd(`RTCCP_IDX_CMP_HIGH, {24'h0, c[15:8]}, `RTCCP_RESP_OKAY);
    wr(`RTCCP_IDX_IRQ_EN, 8'h02, `RTCCP_RESP_OKAY);
    wait_irq();
    `CHK("cmp_hit", c, n_ticks)
    rd(`RTCCP_IDX_IRQ_STAT, 32'h2, `RTCCP_RESP_OKAY);
    wr(`RTCCP_IDX_IRQ_EN, 8'h00, `RTCCP_RESP_OKAY);
    repeat (2) @(posedge core_clk);
    `CHK("irq_masked", 1'b0, o_irq)
    wr(`RTCCP_IDX_IRQ_CLR, 8'h02, `RTCCP_RESP_OKAY);
    rd(`RTCCP_IDX_IRQ_STAT, 32'h0, `RTCCP_RESP_OKAY);
    tick_on <= 1'b0;
    wr(`RTCCP_IDX_PER_IRQEN, 8'h01, `RTCCP_RESP_OKAY);
    wr(`RTCCP_IDX_PER_CTRL, 8'h09, `RTCCP_RESP_OKAY);
    rd(`RTCCP_IDX_PER_STAT, 32'h1, `RTCCP_RESP_OKAY);
    rd(`RTCCP_IDX_PER_CTRL, 32'h9, `RTCCP_RESP_OKAY);
    tick_on <= 1'b1;
    wait_sync();
    `CHK("busy", 1'b0, rv[0])
    wait_irq();
    tick_on <= 1'b0;
    `CHK("irq", 1'b1, o_irq)
    rd(`RTCCP_IDX_PER_FLAG, 32'h1, `RTCCP_RESP_OKAY);
    wr(`RTCCP_IDX_PER_IRQEN, 8'h00, `RTCCP_RESP_OKAY);
    repeat (2) @(posedge core_clk);
    `CHK("irq_gated", 1'b0, o_irq)
    wr(`RTCCP_IDX_PER_IRQEN, 8'h01, `RTCCP_RESP_OKAY);
    wr(`RTCCP_IDX_PER_FLAG, 8'h00, `RTCCP_RESP_OKAY);
    rd(`RTCCP_IDX_PER_FLAG, 32'h1, `RTCCP_RESP_OKAY);
    wr(`RTCCP_IDX_PER_FLAG, 8'h01, `RTCCP_RESP_OKAY);
    rd(`RTCCP_IDX_PER_FLAG, 32'h0, `RTCCP_RESP_OKAY);
    repeat (2) @(posedge core_clk);
    `CHK("irq_clr", 1'b0, o_irq)
    dbg_halt <= 1'b1;
    tick_on <= 1'b1;
    repeat (600) @(posedge core_clk);
    tick_on <= 1'b0;
    rd(`RTCCP_IDX_PER_FLAG, 32'h0, `RTCCP_RESP_OKAY);
    wr(`RTCCP_IDX_PER_DBG, 8'h01, `RTCCP_RESP_OKAY);
    rd(`RTCCP_IDX_PER_DBG, 32'h1, `RTCCP_RESP_OKAY);
    tick_on <= 1'b1;
    wait_irq();
    tick_on <= 1'b0;
    rd(`RTCCP_IDX_PER_FLAG, 32'h1, `RTCCP_RESP_OKAY);
    dbg_halt <= 1'b0;
    // The reserved code must act as off, and a cleared enable must stop the timer.
    foreach (ctl[i]) begin
      wr(`RTCCP_IDX_PER_CTRL, ctl[i], `RTCCP_RESP_OKAY);
      tick_on <= 1'b1;
      wait_sync();
      wr(`RTCCP_IDX_PER_FLAG, 8'h01, `RTCCP_RESP_OKAY);
      repeat (600) @(posedge core_clk);
      rd(`RTCCP_IDX_PER_FLAG, 32'h0, `RTCCP_RESP_OKAY);
    end
    // The timer must follow the selected clock source, counted tick by tick.
    tick_on <= 1'b0;
    wr(`RTCCP_IDX_CLK_SEL, 8'h03, `RTCCP_RESP_OKAY);
    rd(`RTCCP_IDX_CLK_SEL, 32'h3, `RTCCP_RESP_OKAY);
    wr(`RTCCP_IDX_PER_CTRL, 8'h09, `RTCCP_RESP_OKAY);
    ext_pulse(1);
    rd(`RTCCP_IDX_PER_STAT, 32'h1, `RTCCP_RESP_OKAY);
    ext_pulse(1);
    rd(`RTCCP_IDX_PER_STAT, 32'h0, `RTCCP_RESP_OKAY);
    ext_pulse(3);
    rd(`RTCCP_IDX_PER_FLAG, 32'h0, `RTCCP_RESP_OKAY);
    ext_pulse(1);
    rd(`RTCCP_IDX_PER_FLAG, 32'h1, `RTCCP_RESP_OKAY);
    wr(`RTCCP_IDX_CLK_SEL, 8'h02, `RTCCP_RESP_OKAY);
    wr(`RTCCP_IDX_PER_FLAG, 8'h01, `RTCCP_RESP_OKAY);
    tick_on <= 1'b1;
    ext_pulse(40);
    rd(`RTCCP_IDX_PER_FLAG, 32'h0, `RTCCP_RESP_OKAY);
    wr(`RTCCP_IDX_CLK_SEL, 8'h01, `RTCCP_RESP_OKAY);
    repeat (600) @(posedge core_clk);
    rd(`RTCCP_IDX_PER_FLAG, 32'h0, `RTCCP_RESP_OKAY);
    wait_irq();
    rd(`RTCCP_IDX_PER_FLAG, 32'h1, `RTCCP_RESP_OKAY);
    results();
  end
endmodule
